// File: hw/ofl_loader.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ofl_loader #(
    parameter int unsigned ICP_WINDOW_CYC = ofl_pkg::ICP_WINDOW_CYC,
    parameter int unsigned PUT_FAST_CYC   = ofl_pkg::PUT_FAST_CYC,
    parameter int unsigned PUT_SLOW_CYC   = ofl_pkg::PUT_SLOW_CYC
) (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    // fuse array
    input  wire logic [12:0] I_OPTION_FUSES,
    // programming pins
    input  wire logic        I_PROG_CLK,
    input  wire logic        I_PROG_DATA,
    output logic             O_PROG_DATA,
    output logic             O_PROG_DATA_OE,
    // program memory read port
    output logic             O_PMEM_RD,
    output logic [15:0]      O_PMEM_ADDR,
    input  wire logic [7:0]  I_PMEM_DATA,
    // register port
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic [7:0]       O_RDATA,
    // applied configuration
    output logic             O_CLK_SRC_FAST,
    output logic             O_POR_LEVEL_LOW,
    output logic             O_RESET_PIN_FUNCTION,
    output logic             O_FAST_PUT_SEL,
    output logic [7:0]       O_WDT_CTRL,
    // start-up control
    output logic             O_CPU_STALL,
    output logic             O_PERIPH_STALL,
    output logic             O_PIN_BORROW,
    output logic             O_LOAD_DONE
);
    ofl_core_if core ();

    // ****************************************
    // fuse synchroniser
    // ****************************************
    logic [12:0] fuse_s1_q;
    logic [12:0] fuse_s2_q;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fuse_s1_q <= ofl_pkg::FUSE_ERASED;
            fuse_s2_q <= ofl_pkg::FUSE_ERASED;
        end else begin
            fuse_s1_q <= I_OPTION_FUSES;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // ****************************************
    // start-up sequence
    // ****************************************
    ofl_pkg::ofl_state_type state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [12:0] opt_q, opt_d;
    logic        load_q, load_d;
    logic [31:0] put_len;

    // the power-up timer runs from reset release and covers the programming window
    assign put_len = opt_q[ofl_pkg::OPT_FAST_PUT] ? PUT_FAST_CYC : PUT_SLOW_CYC;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        opt_d   = opt_q;
        load_d  = 1'b0;
        if (state_q != ofl_pkg::ST_RUN) begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
        case (state_q)
            ofl_pkg::ST_POR: begin
                if (cnt_q >= 32'(ofl_pkg::SAMPLE_WAIT)) begin
                    state_d = ofl_pkg::ST_SAMPLE;
                end
            end
            ofl_pkg::ST_SAMPLE: begin
                // single capture; nothing else writes opt_q until the next reset
                opt_d   = fuse_s2_q ^ ofl_pkg::FUSE_ERASED;
                load_d  = 1'b1;
                state_d = ofl_pkg::ST_ICP;
            end
            ofl_pkg::ST_ICP: begin
                // hard window; a transfer cut off at the end is simply dropped
                if (cnt_q >= ICP_WINDOW_CYC) begin
                    state_d = ofl_pkg::ST_PUT;
                end
            end
            ofl_pkg::ST_PUT: begin
                if (cnt_q >= put_len) begin
                    state_d = ofl_pkg::ST_RUN;
                end
            end
            ofl_pkg::ST_RUN: begin
                state_d = ofl_pkg::ST_RUN;
            end
            default: begin
                state_d = ofl_pkg::ST_POR;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_q <= ofl_pkg::ST_POR;
            cnt_q   <= 32'h0000_0000;
            opt_q   <= 13'h0000;
            load_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            opt_q   <= opt_d;
            load_q  <= load_d;
        end
    end

    // ****************************************
    // applied configuration outputs
    // ****************************************
    logic clk_fast_q, clk_fast_d;
    logic por_low_q, por_low_d;
    logic rst_fn_q, rst_fn_d;
    logic fast_power_up_option_q, fast_power_up_option_d;
    logic stall_q, stall_d;
    logic borrow_q, borrow_d;
    logic done_q, done_d;

    always_comb begin
        clk_fast_d = clk_fast_q;
        por_low_d  = por_low_q;
        rst_fn_d   = rst_fn_q;
        fast_power_up_option_d     = fast_power_up_option_q;
        done_d     = done_q;
        if (load_q) begin
            clk_fast_d = opt_q[ofl_pkg::OPT_CLK_SRC];
            por_low_d  = opt_q[ofl_pkg::OPT_RST_LVL];
            rst_fn_d   = ~opt_q[ofl_pkg::OPT_RST_IO];
            fast_power_up_option_d     = opt_q[ofl_pkg::OPT_FAST_PUT];
            done_d     = 1'b1;
        end
        stall_d  = (state_d != ofl_pkg::ST_RUN);
        borrow_d = (state_d == ofl_pkg::ST_ICP);
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            clk_fast_q <= 1'b0;
            por_low_q  <= 1'b0;
            rst_fn_q   <= 1'b1;
            fast_power_up_option_q     <= 1'b0;
            stall_q    <= 1'b1;
            borrow_q   <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            clk_fast_q <= clk_fast_d;
            por_low_q  <= por_low_d;
            rst_fn_q   <= rst_fn_d;
            fast_power_up_option_q     <= fast_power_up_option_d;
            stall_q    <= stall_d;
            borrow_q   <= borrow_d;
            done_q     <= done_d;
        end
    end

    // ****************************************
    // program memory read for the programmer
    // ****************************************
    logic        rd_q, rd_d;
    logic [15:0] maddr_q, maddr_d;
    logic        mvalid_q, mvalid_d;
    logic [7:0]  mbyte_q, mbyte_d;

    always_comb begin
        rd_d     = core.mem_req;
        maddr_d  = core.mem_req ? core.mem_addr : maddr_q;
        mvalid_d = rd_q;
        mbyte_d  = mbyte_q;
        if (rd_q) begin
            mbyte_d = opt_q[ofl_pkg::OPT_LOCK] ? ofl_pkg::LOCKED_BYTE : I_PMEM_DATA;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_q     <= 1'b0;
            maddr_q  <= 16'h0000;
            mvalid_q <= 1'b0;
            mbyte_q  <= 8'h00;
        end else begin
            rd_q     <= rd_d;
            maddr_q  <= maddr_d;
            mvalid_q <= mvalid_d;
            mbyte_q  <= mbyte_d;
        end
    end

    // ****************************************
    // register port
    // ****************************************
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (I_RD) begin
            if (I_ADDR == ofl_pkg::REG_WDT_CTRL) begin
                rdata_d = core.wdt_ctrl;
            end else if (I_ADDR == ofl_pkg::REG_OPT_STAT) begin
                rdata_d = opt_q[7:0];
            end else if (I_ADDR == ofl_pkg::REG_DEV_CTRL) begin
                rdata_d = {3'h0, opt_q[12:8]};
            end else if (I_ADDR == ofl_pkg::REG_LOAD_STAT) begin
                rdata_d = {3'h0, done_q, fast_power_up_option_q, rst_fn_q, por_low_q, clk_fast_q};
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // core link and leaf modules
    // ****************************************
    assign core.icp_en    = (state_q == ofl_pkg::ST_ICP);
    assign core.opt       = opt_q;
    assign core.mem_valid = mvalid_q;
    assign core.mem_byte  = mbyte_q;
    assign core.wdt_load  = load_q;
    // software is stalled until run, so earlier strobes are ignored
    assign core.sw_wr     = I_WR && (I_ADDR == ofl_pkg::REG_WDT_CTRL) && (state_q == ofl_pkg::ST_RUN);
    assign core.sw_data   = I_WDATA;

    ofl_icp_slave u_icp (
        .i_clk          (I_CLK),
        .i_rst_n        (I_RST_N),
        .i_prog_clk     (I_PROG_CLK),
        .i_prog_data    (I_PROG_DATA),
        .o_prog_data    (O_PROG_DATA),
        .o_prog_data_oe (O_PROG_DATA_OE),
        .bus            (core.prog)
    );

    ofl_wdt_ctrl u_wdt (
        .i_clk   (I_CLK),
        .i_rst_n (I_RST_N),
        .bus     (core.wdt)
    );

    assign O_PMEM_RD            = rd_q;
    assign O_PMEM_ADDR          = maddr_q;
    assign O_RDATA              = rdata_q;
    assign O_CLK_SRC_FAST       = clk_fast_q;
    assign O_POR_LEVEL_LOW      = por_low_q;
    assign O_RESET_PIN_FUNCTION = rst_fn_q;
    assign O_FAST_PUT_SEL       = fast_power_up_option_q;
    assign O_WDT_CTRL           = core.wdt_ctrl;
    assign O_CPU_STALL          = stall_q;
    assign O_PERIPH_STALL       = stall_q;
    assign O_PIN_BORROW         = borrow_q;
    assign O_LOAD_DONE          = done_q;
endmodule // ofl_loader

// File: pkg/ofl_pkg.sv
package ofl_pkg;

    // ****************************************
    // option bit positions
    // ****************************************
    localparam int          OPT_W         = 13;
    localparam int          OPT_LOCK      = 0;
    localparam int          OPT_CLK_SRC   = 1;
    localparam int          OPT_RST_LVL   = 2;
    localparam int          OPT_WDT_WP    = 3;
    localparam int          OPT_NONSTOP   = 4;
    localparam int          OPT_HW_START  = 5;
    localparam int          OPT_WDT_RST   = 6;
    localparam int          OPT_IDLE      = 7;
    localparam int          OPT_PS0       = 8;
    localparam int          OPT_PS1       = 9;
    localparam int          OPT_PS2       = 10;
    localparam int          OPT_RST_IO    = 11;
    localparam int          OPT_FAST_PUT  = 12;
    // erased fuse cells read high; erased means disabled
    localparam logic [12:0] FUSE_ERASED   = 13'h1FFF;

    // ****************************************
    // watchdog control register fields
    // ****************************************
    localparam int          WDT_RST_EN    = 7;
    localparam int          WDT_NONSTOP   = 6;
    localparam int          WDT_RUN       = 5;
    localparam int          WDT_IDLE      = 3;
    localparam int          WDT_PS_LO     = 0;
    localparam logic [7:0]  WDT_RESET     = 8'h00;
    localparam logic [7:0]  WDT_PROT_MASK = 8'hEF;

    // ****************************************
    // register port
    // ****************************************
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  REG_WDT_CTRL  = 4'h0;
    localparam logic [3:0]  REG_OPT_STAT  = 4'h1;
    localparam logic [3:0]  REG_DEV_CTRL  = 4'h2;
    localparam logic [3:0]  REG_LOAD_STAT = 4'h3;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_MHZ       = 200;
    localparam int          SAMPLE_WAIT   = 3;
    localparam int          ICP_WINDOW_US = 8000;
    localparam int          PUT_FAST_US   = 12000;
    localparam int          PUT_SLOW_US   = 20000;
    // window is strictly shorter than its figure
    localparam int          ICP_WINDOW_CYC = ICP_WINDOW_US * CLK_MHZ - 1;
    localparam int          PUT_FAST_CYC   = PUT_FAST_US * CLK_MHZ - 1;
    localparam int          PUT_SLOW_CYC   = PUT_SLOW_US * CLK_MHZ;

    // ****************************************
    // programming port
    // ****************************************
    localparam logic [7:0]  CMD_READ_CODE = 8'h01;
    localparam logic [7:0]  CMD_READ_OPT  = 8'h02;
    localparam logic [7:0]  LOCKED_BYTE   = 8'h00;

    typedef enum logic [4:0] {
        ST_POR    = 5'h01,
        ST_SAMPLE = 5'h02,
        ST_ICP    = 5'h04,
        ST_PUT    = 5'h08,
        ST_RUN    = 5'h10
    } ofl_state_type;

    typedef enum logic [3:0] {
        ICP_CMD    = 4'h1,
        ICP_ADDR   = 4'h2,
        ICP_WAIT   = 4'h4,
        ICP_ANSWER = 4'h8
    } ofl_icp_state_type;

endpackage

// File: pkg/ofl_core_if.sv
`timescale 1ns/1ps
interface ofl_core_if;
    logic        icp_en;
    logic [12:0] opt;
    logic        mem_req;
    logic [15:0] mem_addr;
    logic        mem_valid;
    logic [7:0]  mem_byte;
    logic        icp_busy;
    logic        wdt_load;
    logic        sw_wr;
    logic [7:0]  sw_data;
    logic [7:0]  wdt_ctrl;

    modport loader (output icp_en, output opt, input mem_req, input mem_addr, output mem_valid,
                    output mem_byte, input icp_busy, output wdt_load, output sw_wr, output sw_data,
                    input wdt_ctrl);
    modport prog   (input icp_en, input opt, output mem_req, output mem_addr, input mem_valid,
                    input mem_byte, output icp_busy);
    modport wdt    (input opt, input wdt_load, input sw_wr, input sw_data, output wdt_ctrl);
endinterface

// File: hw/ofl_wdt_ctrl.sv
`timescale 1ns/1ps
module ofl_wdt_ctrl (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // core link
    ofl_core_if.wdt   bus
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (bus.wdt_load) begin
            ctrl_d                        = ofl_pkg::WDT_RESET;
            ctrl_d[ofl_pkg::WDT_NONSTOP]  = bus.opt[ofl_pkg::OPT_NONSTOP];
            ctrl_d[ofl_pkg::WDT_RST_EN]   = bus.opt[ofl_pkg::OPT_WDT_RST];
            if (bus.opt[ofl_pkg::OPT_HW_START]) begin
                ctrl_d[ofl_pkg::WDT_RUN]  = 1'b1;
                ctrl_d[ofl_pkg::WDT_IDLE] = bus.opt[ofl_pkg::OPT_IDLE];
                ctrl_d[ofl_pkg::WDT_PS_LO +: 3] = {bus.opt[ofl_pkg::OPT_PS2], bus.opt[ofl_pkg::OPT_PS1],
                                                   bus.opt[ofl_pkg::OPT_PS0]};
            end
        end else if (bus.sw_wr) begin
            // protected fields keep their value, the spare bit stays writable
            if (bus.opt[ofl_pkg::OPT_WDT_WP]) begin
                ctrl_d = (ctrl_q & ofl_pkg::WDT_PROT_MASK) | (bus.sw_data & ~ofl_pkg::WDT_PROT_MASK);
            end else begin
                ctrl_d = bus.sw_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= ofl_pkg::WDT_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign bus.wdt_ctrl = ctrl_q;
endmodule // ofl_wdt_ctrl

// File: hw/ofl_icp_slave.sv
`timescale 1ns/1ps
module ofl_icp_slave (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // programming pins
    input  wire logic i_prog_clk,
    input  wire logic i_prog_data,
    output logic      o_prog_data,
    output logic      o_prog_data_oe,
    // core link
    ofl_core_if.prog  bus
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] clk_sync_q;
    logic [1:0] dat_sync_q;
    logic       rise;
    logic       fall;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            clk_sync_q <= 3'h0;
            dat_sync_q <= 2'h0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], i_prog_clk};
            dat_sync_q <= {dat_sync_q[0], i_prog_data};
        end
    end

    assign rise = clk_sync_q[1] & ~clk_sync_q[2];
    assign fall = ~clk_sync_q[1] & clk_sync_q[2];

    // ****************************************
    // command shifter
    // ****************************************
    ofl_pkg::ofl_icp_state_type st_q, st_d;
    logic [15:0] sh_q, sh_d;
    logic [4:0]  cnt_q, cnt_d;
    logic        req_q, req_d;
    logic        dout_q, dout_d;
    logic        oe_q, oe_d;

    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        req_d  = 1'b0;
        dout_d = dout_q;
        oe_d   = oe_q;
        if (!bus.icp_en) begin
            st_d  = ofl_pkg::ICP_CMD;
            cnt_d = 5'h00;
            oe_d  = 1'b0;
        end else begin
            case (st_q)
                ofl_pkg::ICP_CMD: begin
                    if (rise) begin
                        sh_d  = {sh_q[14:0], dat_sync_q[1]};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'h07) begin
                            cnt_d = 5'h00;
                            if (sh_d[7:0] == ofl_pkg::CMD_READ_CODE) begin
                                st_d = ofl_pkg::ICP_ADDR;
                            end else if (sh_d[7:0] == ofl_pkg::CMD_READ_OPT) begin
                                sh_d   = {3'h0, bus.opt};
                                cnt_d  = 5'h10;
                                dout_d = 1'b0;
                                oe_d   = 1'b1;
                                st_d   = ofl_pkg::ICP_ANSWER;
                            end
                        end
                    end
                end
                ofl_pkg::ICP_ADDR: begin
                    if (rise) begin
                        sh_d  = {sh_q[14:0], dat_sync_q[1]};
                        cnt_d = cnt_q + 5'h01;
                        if (cnt_q == 5'h0F) begin
                            req_d = 1'b1;
                            st_d  = ofl_pkg::ICP_WAIT;
                        end
                    end
                end
                ofl_pkg::ICP_WAIT: begin
                    if (bus.mem_valid) begin
                        sh_d   = {bus.mem_byte, 8'h00};
                        cnt_d  = 5'h08;
                        dout_d = bus.mem_byte[7];
                        oe_d   = 1'b1;
                        st_d   = ofl_pkg::ICP_ANSWER;
                    end
                end
                ofl_pkg::ICP_ANSWER: begin
                    // host samples at the end of each high phase, next bit goes out on falling edges
                    if (fall) begin
                        sh_d   = {sh_q[14:0], 1'b0};
                        dout_d = sh_q[14];
                        cnt_d  = cnt_q - 5'h01;
                        if (cnt_q == 5'h01) begin
                            oe_d = 1'b0;
                            st_d = ofl_pkg::ICP_CMD;
                        end
                    end else if (cnt_q == 5'h10) begin
                        dout_d = sh_q[15];
                    end
                end
                default: begin
                    st_d = ofl_pkg::ICP_CMD;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q   <= ofl_pkg::ICP_CMD;
            sh_q   <= 16'h0000;
            cnt_q  <= 5'h00;
            req_q  <= 1'b0;
            dout_q <= 1'b0;
            oe_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            req_q  <= req_d;
            dout_q <= dout_d;
            oe_q   <= oe_d;
        end
    end

    assign o_prog_data    = dout_q;
    assign o_prog_data_oe = oe_q;
    assign bus.mem_req    = req_q;
    assign bus.mem_addr   = sh_q;
    assign bus.icp_busy   = (st_q != ofl_pkg::ICP_CMD) || (cnt_q != 5'h00);
endmodule // ofl_icp_slave

// File: testbench/ofl_loader_chk.sv
`timescale 1ns/1ps
module ofl_loader_chk (
    // clock and reset
    input wire logic        I_CLK,
    input wire logic        I_RST_N,
    // watched inputs
    input wire logic [12:0] I_OPTION_FUSES,
    input wire logic [3:0]  I_ADDR,
    input wire logic [7:0]  I_WDATA,
    input wire logic        I_WR,
    input wire logic        I_RD,
    // watched outputs
    input wire logic [7:0]  O_RDATA,
    input wire logic        O_CLK_SRC_FAST,
    input wire logic        O_POR_LEVEL_LOW,
    input wire logic        O_RESET_PIN_FUNCTION,
    input wire logic        O_FAST_PUT_SEL,
    input wire logic [7:0]  O_WDT_CTRL,
    input wire logic        O_CPU_STALL,
    input wire logic        O_PERIPH_STALL,
    input wire logic        O_PIN_BORROW,
    input wire logic        O_LOAD_DONE,
    input wire logic        O_PROG_DATA_OE,
    input wire logic        O_PMEM_RD
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    chk_borrow_stall: assert property (O_PIN_BORROW |-> O_CPU_STALL && O_PERIPH_STALL)
        else $error("core not stalled in window");
    chk_oe_window: assert property (O_PROG_DATA_OE |-> O_PIN_BORROW || $past(O_PIN_BORROW))
        else $error("data pin driven outside window");
    chk_cfg_hold: assert property (O_LOAD_DONE && $past(O_LOAD_DONE) |->
        $stable({O_CLK_SRC_FAST, O_POR_LEVEL_LOW, O_RESET_PIN_FUNCTION, O_FAST_PUT_SEL})) else $error("config moved");
    chk_wdt_locked: assert property (O_CPU_STALL && $past(O_LOAD_DONE) |-> $stable(O_WDT_CTRL))
        else $error("watchdog control moved in start-up");
    chk_wp_keep: assert property (I_WR && I_ADDR == 4'h0 && !O_CPU_STALL && !I_OPTION_FUSES[3] |=>
        ((O_WDT_CTRL ^ $past(O_WDT_CTRL)) & ofl_pkg::WDT_PROT_MASK) == 8'h00) else $error("protected field written");
    chk_wr_free: assert property (I_WR && I_ADDR == 4'h0 && !O_CPU_STALL && I_OPTION_FUSES[3] |=>
        O_WDT_CTRL == $past(I_WDATA)) else $error("free write lost");
    chk_rd_wdt: assert property (I_RD && I_ADDR == 4'h0 |=> O_RDATA == $past(O_WDT_CTRL))
        else $error("watchdog readback wrong");
    chk_pmem_pulse: assert property (O_PMEM_RD |-> O_PIN_BORROW ##1 !O_PMEM_RD)
        else $error("code read outside window or long");
    cover property (I_WR && !O_CPU_STALL);
    cover property (O_PROG_DATA_OE);
    cover property ($fell(O_CPU_STALL));
endmodule // ofl_loader_chk

bind ofl_loader ofl_loader_chk ofl_loader_chk_inst (.I_CLK, .I_RST_N, .I_OPTION_FUSES, .I_ADDR, .I_WDATA, .I_WR,
    .I_RD, .O_RDATA, .O_CLK_SRC_FAST, .O_POR_LEVEL_LOW, .O_RESET_PIN_FUNCTION, .O_FAST_PUT_SEL, .O_WDT_CTRL,
    .O_CPU_STALL, .O_PERIPH_STALL, .O_PIN_BORROW, .O_LOAD_DONE, .O_PROG_DATA_OE, .O_PMEM_RD);

// File: testbench/ofl_prog_model.sv
`timescale 1ns/1ps
module ofl_prog_model (
    input  wire logic i_clk,
    input  wire logic i_dev_data,
    input  wire logic i_dev_oe,
    output logic      o_prog_clk,
    output logic      o_line
);
    logic host_oe = 1'b0;
    logic host_d  = 1'b0;
    initial o_prog_clk = 1'b0;
    // released line floats to the pin pull-up
    assign o_line = i_dev_oe ? i_dev_data : (host_oe ? host_d : 1'b1);
    // clock stands low between frames; half periods of 8 cycles
    task automatic xfer(input int no, input logic [23:0] dout, input int ni, output logic [15:0] din);
        din = 16'h0000;
        for (int i = no - 1; i >= 0; i--) begin
            o_prog_clk <= 1'b0;
            host_oe    <= 1'b1;
            host_d     <= dout[i];
            repeat (8) @(posedge i_clk);
            o_prog_clk <= 1'b1;
            @(posedge i_clk);
            // let go early so the answer never meets a driven line
            host_oe    <= (i != 0);
            repeat (7) @(posedge i_clk);
        end
        // every fall moves the device on, the one closing the last command bit too,
        // so each bit is taken at the end of its high phase and the frame ends low
        for (int i = 0; i < ni; i++) begin
            if (i != 0) begin
                o_prog_clk <= 1'b1;
                repeat (8) @(posedge i_clk);
            end
            din = {din[14:0], o_line};
            o_prog_clk <= 1'b0;
            repeat (8) @(posedge i_clk);
        end
    endtask
endmodule // ofl_prog_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int WIN   = 2000;
    localparam int PFAST = 3000;
    localparam int PSLOW = 4000;
    logic        I_CLK = 1'b0, I_RST_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic [12:0] I_OPTION_FUSES = 13'h1FFF;
    logic [3:0]  I_ADDR = 4'h0;
    logic [7:0]  I_WDATA = 8'h00, I_PMEM_DATA, O_RDATA, O_WDT_CTRL;
    logic [15:0] O_PMEM_ADDR;
    logic        I_PROG_CLK, I_PROG_DATA, O_PROG_DATA, O_PROG_DATA_OE, O_PMEM_RD, O_CLK_SRC_FAST, O_POR_LEVEL_LOW;
    logic        O_RESET_PIN_FUNCTION, O_FAST_PUT_SEL, O_CPU_STALL, O_PERIPH_STALL, O_PIN_BORROW, O_LOAD_DONE;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    initial forever #2.5 I_CLK = ~I_CLK;
    always @(posedge I_CLK) cyc <= I_RST_N ? cyc + 1 : 0;
    function automatic logic [7:0] pm(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign I_PMEM_DATA = pm(O_PMEM_ADDR);
    function automatic logic [7:0] wdt_exp(input logic [12:0] f);
        return {~f[6], ~f[4], ~f[5], 1'b0, ~f[5] & ~f[7], {3{~f[5]}} & ~f[10:8]};
    endfunction
    ofl_loader #(.ICP_WINDOW_CYC(WIN), .PUT_FAST_CYC(PFAST), .PUT_SLOW_CYC(PSLOW)) ofl_loader_inst (.I_CLK, .I_RST_N,
        .I_OPTION_FUSES, .I_PROG_CLK, .I_PROG_DATA, .O_PROG_DATA, .O_PROG_DATA_OE, .O_PMEM_RD, .O_PMEM_ADDR, .I_PMEM_DATA,
        .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_CLK_SRC_FAST, .O_POR_LEVEL_LOW, .O_RESET_PIN_FUNCTION,
        .O_FAST_PUT_SEL, .O_WDT_CTRL, .O_CPU_STALL, .O_PERIPH_STALL, .O_PIN_BORROW, .O_LOAD_DONE);
    ofl_prog_model ofl_prog_model_inst (.i_clk(I_CLK), .i_dev_data(O_PROG_DATA), .i_dev_oe(O_PROG_DATA_OE),
        .o_prog_clk(I_PROG_CLK), .o_line(I_PROG_DATA));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD   <= 1'b0;
        @(negedge I_CLK);
        d = O_RDATA;
        @(posedge I_CLK);
    endtask
    task automatic run_one(input logic [12:0] f);
        logic [15:0] v, a;
        logic [7:0]  d, g;
        a = 16'($urandom);
        d = 8'($urandom);
        I_OPTION_FUSES <= f;
        I_RST_N        <= 1'b0;
        repeat (16) @(posedge I_CLK);
        I_RST_N        <= 1'b1;
        ofl_prog_model_inst.xfer(8, 24'h00_0002, 16, v);
        chk("opt_read", {3'b000, ~f}, v);
        ofl_prog_model_inst.xfer(24, {8'h01, a}, 8, v);
        chk("code_read", f[0] ? {8'h00, pm(a)} : 16'h0000, v);
        chk("clk_src", !f[1], O_CLK_SRC_FAST);
        chk("por_low", !f[2], O_POR_LEVEL_LOW);
        chk("rst_fn", f[11], O_RESET_PIN_FUNCTION);
        chk("fast_power_up_option", !f[12], O_FAST_PUT_SEL);
        chk("wdt_ctrl", wdt_exp(f), O_WDT_CTRL);
        while (O_CPU_STALL !== 1'b0 && cyc < 6000) @(posedge I_CLK);
        chk("put_len", 1'b1, f[12] ? (cyc >= PSLOW && cyc < 6000) : (cyc >= PFAST && cyc < PSLOW));
        // window closed: nothing answers, the line stays at its pull-up
        ofl_prog_model_inst.xfer(8, 24'h00_0002, 16, v);
        chk("late_prog", 16'hFFFF, v);
        wr(4'h0, d);
        rd(4'h0, g);
        chk("wdt_wr", f[3] ? d : ((wdt_exp(f) & ofl_pkg::WDT_PROT_MASK) | (d & ~ofl_pkg::WDT_PROT_MASK)), g);
        rd(4'hF, g);
        chk("unmapped", 8'h00, g);
        rd(4'h1, g);
        chk("opt_lo", {~f[7:0]}, g);
        rd(4'h3, g);
        chk("load_stat", {4'b0001, !f[12], f[11], !f[2], !f[1]}, g);
        // fuses moving after start-up must not reach the outputs
        I_OPTION_FUSES <= ~f;
        repeat (8) @(posedge I_CLK);
        chk("hold", {!f[1], !f[2], f[11], !f[12]}, {O_CLK_SRC_FAST, O_POR_LEVEL_LOW, O_RESET_PIN_FUNCTION, O_FAST_PUT_SEL});
    endtask
    initial begin
        void'($urandom(79412));
        // erased part: all disabled, reset pin keeps its reset function
        run_one(ofl_pkg::FUSE_ERASED);
        run_one(13'h0000);
        repeat (3) run_one(13'($urandom));
        close_out();
    end
    initial begin
        #300000;
        err_total++;
        close_out();
    end
endmodule // tb
